// ---- rtl/ttss_pkg.sv ----
// Shared constants and types for the texture filter stage and its polygon source
package ttss_pkg;
    localparam int COLOR_W = 8;
    localparam int FRAC_W = 8;
    localparam int LOD_INT_W = 4;
    localparam int COORD_W = 16;
    localparam int SUB_W = 8;
    localparam int ADDR_W = 24;
    localparam int BF_W = 3;
    localparam logic [COORD_W-1:0] HALF_TEXEL = 16'h0080;
    localparam logic [FRAC_W-1:0] FRAC_ONE_M1 = 8'hff;
    localparam logic [1:0] BILIN_TAPS_M1 = 2'h3;
    localparam logic [1:0] SUPER_POINTS_M1 = 2'h3;
    localparam logic [BF_W-1:0] BF_ZERO = 3'h0;
    localparam logic [BF_W-1:0] BF_ONE = 3'h1;
    localparam logic [BF_W-1:0] BF_SRC_ALPHA = 3'h4;
    localparam logic [BF_W-1:0] BF_INV_SRC_ALPHA = 3'h5;

    typedef enum logic [1:0] {FILTER_POINT, FILTER_BILINEAR, FILTER_TRI_A, FILTER_TRI_B}
        ttss_filter_e;
    typedef enum logic [1:0] {KIND_OPAQUE, KIND_TRANSLUCENT, KIND_PUNCH} ttss_kind_e;

    typedef struct packed {
        logic [COLOR_W-1:0] a;
        logic [COLOR_W-1:0] r;
        logic [COLOR_W-1:0] g;
        logic [COLOR_W-1:0] b;
    } ttss_argb_s;

    // Scale one channel by a 9-bit weight where 9'h100 stands for one
    function automatic logic [15:0] ttss_wmul(input logic [7:0] c, input logic [8:0] w);
        logic [16:0] p;
        p = {9'h000, c} * {8'h00, w};
        return p[15:0];
    endfunction
endpackage

// ---- rtl/ttss_link_if.sv ----
// Link between the polygon source and the filter stage
`timescale 1ns/1ps
interface ttss_link_if;
    logic reqValid;
    logic reqReady;
    logic [ttss_pkg::COORD_W-1:0] u;
    logic [ttss_pkg::COORD_W-1:0] v;
    logic [ttss_pkg::LOD_INT_W+ttss_pkg::FRAC_W-1:0] detail;
    ttss_pkg::ttss_filter_e filterMode;
    ttss_pkg::ttss_kind_e polyKind;
    logic superSample;
    logic source_buffer_select;
    logic dest_buffer_select;
    logic [ttss_pkg::BF_W-1:0] source_blend_factor;
    logic [ttss_pkg::BF_W-1:0] dest_blend_factor;
    ttss_pkg::ttss_argb_s baseColor;
    ttss_pkg::ttss_argb_s secondaryPixel;
    logic texReq;
    logic [ttss_pkg::ADDR_W-1:0] texAddr;
    logic texValid;
    ttss_pkg::ttss_argb_s texData;
    logic pixValid;
    ttss_pkg::ttss_argb_s pixColor;
    logic pixDestSecondary;
    logic [ttss_pkg::BF_W-1:0] pixSrcFactor;
    logic [ttss_pkg::BF_W-1:0] pixDstFactor;
    logic pixError;

    modport device (
        input reqValid, u, v, detail, filterMode, polyKind, superSample,
        input source_buffer_select, dest_buffer_select, source_blend_factor,
        input dest_blend_factor, baseColor, secondaryPixel, texValid, texData,
        output reqReady, texReq, texAddr, pixValid, pixColor, pixDestSecondary,
        output pixSrcFactor, pixDstFactor, pixError
    );
    modport source (
        output reqValid, u, v, detail, filterMode, polyKind, superSample,
        output source_buffer_select, dest_buffer_select, source_blend_factor,
        output dest_blend_factor, baseColor, secondaryPixel, texValid, texData,
        input reqReady, texReq, texAddr, pixValid, pixColor, pixDestSecondary,
        input pixSrcFactor, pixDstFactor, pixError
    );
endinterface

// ---- rtl/ttss_weight.sv ----
// Weighted accumulation of one texel into four channel sums
`timescale 1ns/1ps
module ttss_weight (
    // Texel and weight
    input wire ttss_pkg::ttss_argb_s texel,
    input wire logic [8:0] weight,
    // Running sums
    input wire logic [19:0] accIn [4],
    output logic [19:0] accOut [4]
);
    always_comb
    begin
        accOut[0] = accIn[0] + {4'h0, ttss_pkg::ttss_wmul(texel.a, weight)};
        accOut[1] = accIn[1] + {4'h0, ttss_pkg::ttss_wmul(texel.r, weight)};
        accOut[2] = accIn[2] + {4'h0, ttss_pkg::ttss_wmul(texel.g, weight)};
        accOut[3] = accIn[3] + {4'h0, ttss_pkg::ttss_wmul(texel.b, weight)};
    end
endmodule // ttss_weight

// ---- rtl/ttss_filter.sv ----
// Texture filter stage: bilinear, tri-linear passes, super-sampling, secondary flush
//
// Contract
// - Tri-linear mixes two mip bilinears, eight texels
// - Pass A: higher level times one minus fraction
// - Pass B: lower level times fraction
// - Opaque two passes, translucent three, same geometry
// - Opaque: pass A one/zero, pass B adds
// - Opaque pass B goes in translucent list
// - Translucent: passes into secondary, then flush
// - Source select 1 passes secondary pixel unchanged
// - Flush pass suggests factors 4 and 5
// - All translucent passes in translucent list
// - Never tri-linear on punch-through polygons
// - Super-sampling takes four half-offset points
// - Super-sampling fetches four times texture data
// - Transparent texels average colour and alpha alike
// - Bilinear weights four neighbouring texels
`timescale 1ns/1ps
module ttss_filter (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Link
    ttss_link_if.device link
);
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_POINT, ST_OUT} ttss_state_e;

    typedef struct packed {
        ttss_state_e state;
        logic [ttss_pkg::COORD_W-1:0] u;
        logic [ttss_pkg::COORD_W-1:0] v;
        logic [ttss_pkg::LOD_INT_W-1:0] level;
        logic [ttss_pkg::FRAC_W-1:0] frac;
        ttss_pkg::ttss_filter_e mode;
        logic superSample;
        logic [1:0] tap;
        logic [1:0] point;
        logic [79:0] acc;
        logic [79:0] sum;
        logic texReq;
        logic [ttss_pkg::ADDR_W-1:0] texAddr;
        logic pixValid;
        ttss_pkg::ttss_argb_s pixColor;
        logic pixDestSecondary;
        logic [ttss_pkg::BF_W-1:0] pixSrcFactor;
        logic [ttss_pkg::BF_W-1:0] pixDstFactor;
        logic pixError;
    } ttss_state_s;

    ttss_state_s cur;
    ttss_state_s next_cur;
    logic [19:0] accIn [4];
    logic [19:0] accOut [4];
    logic [8:0] tapWeight;
    logic [31:0] tapCoord;

    // Texel address from level and integer texel coordinate
    function automatic logic [ttss_pkg::ADDR_W-1:0] texelAddr(
        input logic [3:0] lvl, input logic [7:0] tu, input logic [7:0] tv);
        return {4'h0, lvl, tv, tu};
    endfunction

    // Bilinear tap weight from the sub-texel position
    function automatic logic [8:0] bilinWeight(input logic [1:0] t,
        input logic [7:0] fu, input logic [7:0] fv);
        logic [8:0] wu;
        logic [8:0] wv;
        logic [17:0] p;
        wu = t[0] ? {1'b0, fu} : 9'h100 - {1'b0, fu};
        wv = t[1] ? {1'b0, fv} : 9'h100 - {1'b0, fv};
        p = {9'h000, wu} * {9'h000, wv};
        return p[16:8];
    endfunction

    // Fetch and weighting share one point, so offset samples blend around that point
    function automatic logic [31:0] pointCoord(input logic [15:0] bu, input logic [15:0] bv,
        input logic [1:0] pt, input logic lower);
        logic [15:0] pu;
        logic [15:0] pv;
        // Super-sample points at (0,0), (.5,0), (0,.5), (.5,.5)
        pu = bu + (pt[0] ? ttss_pkg::HALF_TEXEL : 16'h0000);
        pv = bv + (pt[1] ? ttss_pkg::HALF_TEXEL : 16'h0000);
        if (lower)
        begin
            // Lower level halves the coordinate
            pu = {1'b0, pu[15:1]};
            pv = {1'b0, pv[15:1]};
        end
        return {pu, pv};
    endfunction

    assign accIn[0] = cur.acc[79:60];
    assign accIn[1] = cur.acc[59:40];
    assign accIn[2] = cur.acc[39:20];
    assign accIn[3] = cur.acc[19:0];
    assign tapCoord = pointCoord(cur.u, cur.v, cur.point, cur.mode == ttss_pkg::FILTER_TRI_B);
    assign tapWeight = (cur.mode == ttss_pkg::FILTER_POINT) ? 9'h100
        : bilinWeight(cur.tap, tapCoord[23:16], tapCoord[7:0]);

    ttss_weight i_ttss_weight (
        .texel(link.texData),
        .weight(tapWeight),
        .accIn(accIn),
        .accOut(accOut)
    );

    always_comb
    begin
        logic [ttss_pkg::COORD_W-1:0] pu;
        logic [ttss_pkg::COORD_W-1:0] pv;
        logic [7:0] tu;
        logic [7:0] tv;
        logic [3:0] lvl;
        logic [8:0] pw;
        logic [19:0] ch;
        logic [15:0] sc;
        ttss_pkg::ttss_argb_s avg;
        pu = '0;
        pv = '0;
        tu = '0;
        tv = '0;
        lvl = '0;
        pw = '0;
        ch = '0;
        sc = '0;
        avg = '0;
        next_cur = cur;
        next_cur.pixValid = 1'b0;
        case (cur.state)
            ST_IDLE:
            begin
                if (link.reqValid)
                begin
                    next_cur.u = link.u;
                    next_cur.v = link.v;
                    next_cur.level = link.detail[11:8];
                    next_cur.frac = link.detail[7:0];
                    next_cur.mode = link.filterMode;
                    next_cur.superSample = link.superSample;
                    next_cur.tap = 2'h0;
                    next_cur.point = 2'h0;
                    next_cur.acc = '0;
                    next_cur.sum = '0;
                    next_cur.pixDestSecondary = link.dest_buffer_select;
                    next_cur.pixSrcFactor = link.source_blend_factor;
                    next_cur.pixDstFactor = link.dest_blend_factor;
                    next_cur.pixError = 1'b0;
                    if (link.source_buffer_select)
                    begin
                        // Flush pass ignores shading and texture entirely
                        next_cur.pixColor = link.secondaryPixel;
                        next_cur.state = ST_OUT;
                    end
                    else if (link.polyKind == ttss_pkg::KIND_PUNCH &&
                        (link.filterMode == ttss_pkg::FILTER_TRI_A ||
                        link.filterMode == ttss_pkg::FILTER_TRI_B))
                    begin
                        next_cur.pixColor = '0;
                        next_cur.pixError = 1'b1;
                        next_cur.state = ST_OUT;
                    end
                    else
                    begin
                        next_cur.state = ST_FETCH;
                    end
                end
            end
            ST_FETCH:
            begin
                pu = tapCoord[31:16];
                pv = tapCoord[15:0];
                lvl = (cur.mode == ttss_pkg::FILTER_TRI_B) ? cur.level + 4'h1 : cur.level;
                tu = pu[15:8] + {7'h00, cur.tap[0]};
                tv = pv[15:8] + {7'h00, cur.tap[1]};
                next_cur.texReq = 1'b1;
                next_cur.texAddr = texelAddr(lvl, tu, tv);
                next_cur.state = ST_WAIT;
            end
            ST_WAIT:
            begin
                next_cur.texReq = 1'b0;
                if (link.texValid)
                begin
                    // Colour and alpha share one weighting path
                    next_cur.acc = {accOut[0], accOut[1], accOut[2], accOut[3]};
                    if (cur.mode != ttss_pkg::FILTER_POINT && cur.tap != ttss_pkg::BILIN_TAPS_M1)
                    begin
                        next_cur.tap = cur.tap + 2'h1;
                        next_cur.state = ST_FETCH;
                    end
                    else
                    begin
                        next_cur.state = ST_POINT;
                    end
                end
            end
            ST_POINT:
            begin
                for (int i = 0; i < 4; i++)
                begin
                    ch = cur.acc[79-20*i -: 20];
                    next_cur.sum[79-20*i -: 20] = cur.sum[79-20*i -: 20]
                        + {8'h00, ch[19:8]};
                end
                next_cur.acc = '0;
                next_cur.tap = 2'h0;
                if (cur.superSample && cur.point != ttss_pkg::SUPER_POINTS_M1)
                begin
                    next_cur.point = cur.point + 2'h1;
                    next_cur.state = ST_FETCH;
                end
                else
                begin
                    next_cur.state = ST_OUT;
                    pw = (cur.mode == ttss_pkg::FILTER_TRI_A)
                        ? 9'h100 - {1'b0, cur.frac}
                        : (cur.mode == ttss_pkg::FILTER_TRI_B) ? {1'b0, cur.frac}
                        : 9'h100;
                    for (int i = 0; i < 4; i++)
                    begin
                        ch = next_cur.sum[79-20*i -: 20];
                        if (cur.superSample)
                            ch = {2'h0, ch[19:2]};
                        sc = ttss_pkg::ttss_wmul(ch[7:0], pw);
                        avg[31-8*i -: 8] = sc[15:8];
                    end
                    next_cur.pixColor = avg;
                end
            end
            ST_OUT:
            begin
                next_cur.pixValid = 1'b1;
                next_cur.state = ST_IDLE;
            end
            default:
            begin
                next_cur.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign link.reqReady = (cur.state == ST_IDLE);
    assign link.texReq = cur.texReq;
    assign link.texAddr = cur.texAddr;
    assign link.pixValid = cur.pixValid;
    assign link.pixColor = cur.pixColor;
    assign link.pixDestSecondary = cur.pixDestSecondary;
    assign link.pixSrcFactor = cur.pixSrcFactor;
    assign link.pixDstFactor = cur.pixDstFactor;
    assign link.pixError = cur.pixError;
endmodule // ttss_filter

// ---- rtl/ttss_source.sv ----
// Polygon source: issues the tri-linear pass sequences and serves texture reads
`timescale 1ns/1ps
module ttss_source (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // User command
    input wire logic startValid,
    output logic startReady,
    input wire logic translucent,
    input wire logic trilinear,
    input wire logic superSample,
    input wire logic [15:0] u,
    input wire logic [15:0] v,
    input wire logic [11:0] detail,
    input wire ttss_pkg::ttss_argb_s baseColor,
    input wire ttss_pkg::ttss_argb_s secondaryPixel,
    // Texture memory
    input wire ttss_pkg::ttss_argb_s memData,
    // Result
    output logic passList,
    output logic done,
    // Link
    ttss_link_if.source link
);
    typedef struct packed {
        logic busy;
        logic [1:0] pass;
        logic texValid;
        ttss_pkg::ttss_argb_s texData;
        logic passList;
        logic done;
    } ttss_src_s;

    ttss_src_s cur;
    ttss_src_s next_cur;
    logic [1:0] lastPass;

    assign lastPass = !trilinear ? 2'h0 : translucent ? 2'h2 : 2'h1;

    always_comb
    begin
        next_cur = cur;
        next_cur.texValid = link.texReq;
        next_cur.texData = memData;
        next_cur.done = 1'b0;
        if (!cur.busy && startValid)
        begin
            next_cur.busy = 1'b1;
            next_cur.pass = 2'h0;
        end
        else if (cur.busy && link.reqValid && link.reqReady)
        begin
            // Second opaque pass and every translucent pass use the translucent list
            next_cur.passList = translucent || cur.pass != 2'h0;
            if (cur.pass == lastPass)
            begin
                next_cur.busy = 1'b0;
                next_cur.done = 1'b1;
            end
            else
            begin
                next_cur.pass = cur.pass + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign startReady = !cur.busy;
    assign passList = cur.passList;
    assign done = cur.done;
    assign link.reqValid = cur.busy;
    assign link.u = u;
    assign link.v = v;
    assign link.detail = detail;
    assign link.superSample = superSample;
    assign link.baseColor = baseColor;
    assign link.secondaryPixel = secondaryPixel;
    assign link.texValid = cur.texValid;
    assign link.texData = cur.texData;
    // Punch-through is never offered tri-linear
    assign link.polyKind = translucent ? ttss_pkg::KIND_TRANSLUCENT
        : ttss_pkg::KIND_OPAQUE;
    assign link.filterMode = !trilinear ? ttss_pkg::FILTER_BILINEAR
        : (cur.pass == 2'h1) ? ttss_pkg::FILTER_TRI_B : ttss_pkg::FILTER_TRI_A;
    assign link.source_buffer_select = trilinear && translucent && cur.pass == 2'h2;
    assign link.dest_buffer_select = trilinear && translucent && cur.pass != 2'h2;
    assign link.source_blend_factor = (link.source_buffer_select)
        ? ttss_pkg::BF_SRC_ALPHA : ttss_pkg::BF_ONE;
    assign link.dest_blend_factor = (link.source_buffer_select) ? ttss_pkg::BF_INV_SRC_ALPHA
        : (cur.pass == 2'h1) ? ttss_pkg::BF_ONE : ttss_pkg::BF_ZERO;
endmodule // ttss_source

// ---- bench/ttss_link_monitor.sv ----
// Concurrent checks on the link between polygon source and filter stage
`timescale 1ns/1ps
module ttss_link_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Request
    input wire logic reqValid,
    input wire logic reqReady,
    input wire ttss_pkg::ttss_filter_e filterMode,
    input wire logic superSample,
    input wire logic source_buffer_select,
    input wire logic dest_buffer_select,
    input wire logic [ttss_pkg::BF_W-1:0] source_blend_factor,
    input wire ttss_pkg::ttss_argb_s secondaryPixel,
    // Texture memory
    input wire logic texReq,
    input wire logic texValid,
    // Pixel result
    input wire logic pixValid,
    input wire ttss_pkg::ttss_argb_s pixColor,
    input wire logic pixDestSecondary,
    input wire logic [ttss_pkg::BF_W-1:0] pixSrcFactor
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    logic take;
    assign take = reqValid && reqReady;

    a_flush_latency: assert property (
        take && source_buffer_select |-> ##2 pixValid)
        else $error("flush pixel not two cycles after request");
    a_flush_color: assert property (
        take && source_buffer_select |-> ##2 pixColor == $past(secondaryPixel, 2))
        else $error("flush pixel differs from secondary pixel");
    a_flush_fields: assert property (
        take && source_buffer_select |-> ##2 pixSrcFactor == $past(source_blend_factor, 2)
        && pixDestSecondary == $past(dest_buffer_select, 2))
        else $error("flush factors or destination not carried");
    a_flush_no_fetch: assert property (
        take && source_buffer_select |-> ##1 !texReq [*2])
        else $error("texture fetched during flush");
    a_bilin_latency: assert property (
        take && !source_buffer_select && !superSample && filterMode != ttss_pkg::FILTER_POINT
        |-> ##1 !pixValid [*8] ##1 !pixValid [*6] ##1 pixValid)
        else $error("four tap pixel not fifteen cycles after request");
    a_super_latency: assert property (
        take && !source_buffer_select && superSample && filterMode != ttss_pkg::FILTER_POINT
        |-> ##54 pixValid)
        else $error("super-sampled pixel not 54 cycles after request");
    a_busy_refuse: assert property (
        take |=> !reqReady)
        else $error("ready stayed high after a request was taken");
    a_pix_pulse: assert property (
        pixValid |=> !pixValid)
        else $error("pixel valid longer than one cycle");
    a_tex_answer: assert property (
        texReq |=> texValid)
        else $error("texel answer missing one cycle after fetch");
endmodule // ttss_link_monitor

// ---- bench/tb_texture_trilinear_supersample.sv ----
// Bench joining polygon source and filter stage, plus a filter driven directly
`timescale 1ns/1ps
module tb_texture_trilinear_supersample;
    typedef struct packed {
        ttss_pkg::ttss_argb_s color;
        logic dest;
        logic [2:0] sf;
        logic [2:0] df;
        logic list;
    } ttss_pix_s;
    localparam ttss_pkg::ttss_argb_s SEC = 32'h3c5a96c3;
    localparam ttss_pkg::ttss_argb_s HALF = 32'h7f7f7f7f;
    logic clock;
    logic reset;
    logic startValid;
    logic startReady;
    logic translucent;
    logic trilinear;
    logic superSample;
    logic [15:0] u;
    logic [15:0] v;
    logic [11:0] detail;
    ttss_pkg::ttss_argb_s baseColor;
    ttss_pkg::ttss_argb_s secondaryPixel;
    ttss_pkg::ttss_argb_s memData;
    logic passList;
    logic done;
    int errors;
    int cmp_count;
    int fetches;
    int dones;
    ttss_pix_s pixQ[$];
    ttss_link_if link();
    ttss_link_if link2();

    ttss_source i_ttss_source (.clock(clock), .reset(reset), .startValid(startValid),
        .startReady(startReady), .translucent(translucent), .trilinear(trilinear),
        .superSample(superSample), .u(u), .v(v), .detail(detail), .baseColor(baseColor),
        .secondaryPixel(secondaryPixel), .memData(memData), .passList(passList),
        .done(done), .link(link));
    ttss_filter i_ttss_filter (.clock(clock), .reset(reset), .link(link));
    ttss_filter i_ttss_filter_b (.clock(clock), .reset(reset), .link(link2));
    ttss_link_monitor i_ttss_link_monitor (.clock(clock), .reset(reset),
        .reqValid(link.reqValid), .reqReady(link.reqReady), .filterMode(link.filterMode),
        .superSample(link.superSample), .source_buffer_select(link.source_buffer_select),
        .dest_buffer_select(link.dest_buffer_select),
        .source_blend_factor(link.source_blend_factor), .secondaryPixel(link.secondaryPixel),
        .texReq(link.texReq), .texValid(link.texValid), .pixValid(link.pixValid),
        .pixColor(link.pixColor), .pixDestSecondary(link.pixDestSecondary),
        .pixSrcFactor(link.pixSrcFactor));

    // Odd texel columns are fully transparent black; outside fetches the bus holds 32'h5a5a5a5a
    assign memData = !link.texReq ? 32'h5a5a5a5a :
        (link.texAddr[0] ? 32'h00000000 : 32'hfefefefe);

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (link.texReq === 1'b1)
            fetches++;
        if (done === 1'b1)
            dones++;
        if (link.pixValid === 1'b1)
            pixQ.push_back({link.pixColor, link.pixDestSecondary, link.pixSrcFactor,
                link.pixDstFactor, passList});
    end

    task check_pix(input string name, input ttss_pix_s exp, input ttss_pix_s got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task check_color(input string name, input ttss_pkg::ttss_argb_s exp,
        input ttss_pkg::ttss_argb_s got);
        check_pix(name, {exp, 8'h00}, {got, 8'h00});
    endtask

    task check_bit(input string name, input logic exp, input logic got);
        check_pix(name, {39'h0, exp}, {39'h0, got});
    endtask

    task check_count(input string name, input int exp, input int got);
        cmp_count++;
        if (got != exp)
        begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // One whole polygon sequence; waits for the expected number of pixels
    task run_seq(input string name, input logic tl, input logic tr, input logic ss,
        input logic [15:0] uu, input logic [11:0] dd, input int n, input int nFetch);
        int k;
        @(negedge clock);
        pixQ.delete();
        fetches = 0;
        dones = 0;
        @(posedge clock);
        startValid <= 1'b1;
        translucent <= tl;
        trilinear <= tr;
        superSample <= ss;
        u <= uu;
        detail <= dd;
        @(negedge clock);
        for (k = 0; k < 200 && startReady !== 1'b1; k++)
            @(negedge clock);
        @(posedge clock);
        startValid <= 1'b0;
        for (k = 0; k < 400 && pixQ.size() < n; k++)
            @(negedge clock);
        repeat (3) @(negedge clock);
        check_count({name, " pixels"}, n, pixQ.size());
        check_count({name, " fetches"}, nFetch, fetches);
        check_count({name, " done"}, 1, dones);
        check_bit({name, " error"}, 1'b0, link.pixError);
        $display("test %s done", name);
    endtask

    // Punch-through polygon asking for a tri-linear pass, on the spare filter
    task punch_req(input ttss_pkg::ttss_filter_e m);
        @(posedge clock);
        link2.reqValid <= 1'b1;
        link2.filterMode <= m;
        @(negedge clock);
        check_bit("punch ready", 1'b1, link2.reqReady);
        @(posedge clock);
        link2.reqValid <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        check_bit("punch valid", 1'b1, link2.pixValid);
        check_bit("punch error", 1'b1, link2.pixError);
        check_color("punch color", 32'h0, link2.pixColor);
        $display("test punch done");
    endtask

    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        errors++;
        finish_test();
    end

    initial
    begin
        errors = 0;
        cmp_count = 0;
        fetches = 0;
        reset = 1'b1;
        startValid = 1'b0;
        translucent = 1'b0;
        trilinear = 1'b0;
        superSample = 1'b0;
        u = 16'h0400;
        v = 16'h0000;
        detail = 12'h000;
        baseColor = 32'h80ffffff;
        secondaryPixel = SEC;
        link2.reqValid = 1'b0;
        link2.u = 16'h0400;
        link2.v = 16'h0000;
        link2.detail = 12'h080;
        link2.filterMode = ttss_pkg::FILTER_TRI_A;
        link2.polyKind = ttss_pkg::KIND_PUNCH;
        link2.superSample = 1'b0;
        link2.source_buffer_select = 1'b0;
        link2.dest_buffer_select = 1'b0;
        link2.source_blend_factor = ttss_pkg::BF_ONE;
        link2.dest_blend_factor = ttss_pkg::BF_ZERO;
        link2.baseColor = 32'h80ffffff;
        link2.secondaryPixel = SEC;
        link2.texValid = 1'b0;
        link2.texData = 32'h0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        run_seq("bilinear", 1'b0, 1'b0, 1'b0, 16'h0400, 12'h000, 1, 4);
        check_color("bilinear color", 32'hfefefefe, pixQ[0].color);
        run_seq("edge", 1'b1, 1'b0, 1'b0, 16'h0280, 12'h000, 1, 4);
        check_color("edge color", HALF, pixQ[0].color);
        run_seq("tri opaque", 1'b0, 1'b1, 1'b0, 16'h0400, 12'h080, 2, 8);
        check_pix("opaque A", {HALF, 1'b0, 3'h1, 3'h0, 1'b0}, pixQ[0]);
        check_pix("opaque B", {HALF, 1'b0, 3'h1, 3'h1, 1'b1}, pixQ[1]);
        run_seq("tri transl", 1'b1, 1'b1, 1'b0, 16'h0400, 12'h180, 3, 8);
        check_pix("transl A", {HALF, 1'b1, 3'h1, 3'h0, 1'b1}, pixQ[0]);
        check_pix("transl B", {HALF, 1'b1, 3'h1, 3'h1, 1'b1}, pixQ[1]);
        check_pix("flush", {SEC, 1'b0, 3'h4, 3'h5, 1'b1}, pixQ[2]);
        run_seq("super", 1'b0, 1'b0, 1'b1, 16'h0400, 12'h000, 1, 16);
        check_color("super color", 32'hbebebebe, pixQ[0].color);
        punch_req(ttss_pkg::FILTER_TRI_A);
        punch_req(ttss_pkg::FILTER_TRI_B);
        finish_test();
    end
endmodule // tb_texture_trilinear_supersample
